// *** tac_cfg.svh ***
// constants of the thermal alert configuration and threshold bank
`ifndef TAC_CFG_SVH
`define TAC_CFG_SVH

// register pointer values
`define TAC_OFS_CONFIG 8'h01
`define TAC_OFS_UPPER 8'h02
`define TAC_OFS_LOWER 8'h03

// configuration word fields
`define TAC_CFG_MODE_BIT 0
`define TAC_CFG_POL_BIT 1
`define TAC_CFG_CRITONLY_BIT 2
`define TAC_CFG_OUTEN_BIT 3
`define TAC_CFG_STATUS_BIT 4
`define TAC_CFG_CLEAR_BIT 5
`define TAC_CFG_WINLOCK_BIT 6
`define TAC_CFG_CRITLOCK_BIT 7
`define TAC_CFG_SHUTDOWN_BIT 8
`define TAC_CFG_HYST_LSB 9
`define TAC_CFG_HYST_MSB 10

// threshold word fields: sign at bit 12, 0.25 degC lsb at bit 2
`define TAC_THR_MSB 12
`define TAC_THR_LSB 2

// reset values
`define TAC_CONFIG_RST 16'h0000
`define TAC_UPPER_RST 16'h0000
`define TAC_LOWER_RST 16'h0000

// hysteresis margins in 0.125 degC steps
`define TAC_HYST_0 14'h0000
`define TAC_HYST_1P5 14'h000c
`define TAC_HYST_3 14'h0018
`define TAC_HYST_6 14'h0030

`endif

// *** tac_pkg.sv ***
// types shared by the thermal alert configuration and threshold bank
package tac_pkg;

  typedef enum logic [1:0] {
    TAC_HYST_OFF = 2'b00,
    TAC_HYST_1P5 = 2'b01,
    TAC_HYST_3 = 2'b10,
    TAC_HYST_6 = 2'b11
  } tac_hyst_t;

  typedef struct packed {
    tac_hyst_t hyst;
    logic shutdown;
    logic critLock;
    logic winLock;
    logic outEn;
    logic critOnly;
    logic activeHigh;
    logic intMode;
  } tac_cfg_t;

  typedef struct packed {
    logic aboveCrit;
    logic aboveWin;
    logic belowWin;
  } tac_trip_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } tac_req_t;

endpackage

// *** tac_hyst_cmp.sv ***
// window and critical comparisons with hysteresis, giving next trip flags
`timescale 1ns/1ps
`default_nettype none
`include "tac_cfg.svh"

module tac_hyst_cmp (
  // sample and limits, all two's complement
  input wire logic [11:0] tempSample,
  input wire logic [10:0] upperLimit,
  input wire logic [10:0] lowerLimit,
  input wire logic [10:0] critLimit,
  input wire tac_pkg::tac_hyst_t hyst,
  // present and next flags
  input wire tac_pkg::tac_trip_t tripNow,
  output tac_pkg::tac_trip_t tripNxt
);

  logic signed [13:0] tExt;
  logic signed [13:0] upExt;
  logic signed [13:0] loExt;
  logic signed [13:0] crExt;
  logic signed [13:0] margin;

  // thresholds move from 0.25 to 0.125 degC steps
  assign tExt = {{2{tempSample[11]}}, tempSample};
  assign upExt = {{2{upperLimit[10]}}, upperLimit, 1'b0};
  assign loExt = {{2{lowerLimit[10]}}, lowerLimit, 1'b0};
  assign crExt = {{2{critLimit[10]}}, critLimit, 1'b0};

  always_comb begin
    unique case (hyst)
      tac_pkg::TAC_HYST_OFF: margin = `TAC_HYST_0;
      tac_pkg::TAC_HYST_1P5: margin = `TAC_HYST_1P5;
      tac_pkg::TAC_HYST_3: margin = `TAC_HYST_3;
      tac_pkg::TAC_HYST_6: margin = `TAC_HYST_6;
    endcase
  end

  always_comb begin
    tripNxt = tripNow;
    if (tExt > upExt) begin
      tripNxt.aboveWin = 1'b1;
    end else if (tExt <= upExt - margin) begin
      tripNxt.aboveWin = 1'b0;
    end
    if (tExt >= loExt) begin
      tripNxt.belowWin = 1'b0;
    end else if (tExt <= loExt - margin) begin
      tripNxt.belowWin = 1'b1;
    end
    if (tExt >= crExt) begin
      tripNxt.aboveCrit = 1'b1;
    end else if (tExt < crExt - margin) begin
      tripNxt.aboveCrit = 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** tac_config_thresholds.sv ***
// configuration word, alarm window limits and alert pin logic
//
// What this block does
// - bit 0 picks comparator or latched mode
// - bit 1 sets alert pin active level
// - bit 2 limits alert to critical trip
// - bit 3 enables alert pin, else inactive
// - bit 4 reads live alert status only
// - bit 5 write clears latched alert, reads 0
// - window lock freezes both window limits
// - critical lock refuses critical limit writes
// - locks and fields update in one write
// - any lock freezes mode, level, enable, hysteresis
// - bit 8 stops monitoring and alerts
// - locked: shutdown may clear, not set
// - bits 10:9 select hysteresis margin
// - hysteresis applies to all comparisons
// - below-window flag set and clear points
// - upper limit: 0.25 degC, sign bit 12
// - lower limit uses same format
// - above-window flag set and clear points
// - comparator mode follows window, ignores access
// - latched mode holds crossings until cleared
// - critical alert holds until below limit minus hysteresis margin
`timescale 1ns/1ps
`default_nettype none
`include "tac_cfg.svh"

module tac_config_thresholds (
  // clock and power-on reset
  input wire logic core_clk,
  input wire logic rst,
  // register access from the serial engine
  input wire tac_pkg::tac_req_t regReq,
  output logic [15:0] rdData,
  output logic rdValid,
  // converter side
  input wire logic [11:0] tempSample,
  input wire logic tempValid,
  input wire logic [10:0] critLimit,
  output logic monitorEn,
  output logic critWrAllow,
  output tac_pkg::tac_trip_t tripStatus,
  // alert pin
  output logic alertOut,
  output logic alertOe
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  tac_pkg::tac_cfg_t cfg_r;
  tac_pkg::tac_cfg_t cfg_nxt;
  logic [10:0] upperLimit_r;
  logic [10:0] lowerLimit_r;
  tac_pkg::tac_trip_t trip_r;
  tac_pkg::tac_trip_t tripNxt;
  logic winOutPrev_r;
  logic intLatch_r;
  logic rdValid_r;
  logic [15:0] rdData_r;
  logic alertOut_r;
  logic alertOe_r;

  logic cfgWr;
  logic upperWr;
  logic lowerWr;
  logic anyLock;
  logic clearReq;
  logic winOut;
  logic crossing;
  logic evtRaw;
  logic evtActive;
  logic [15:0] wd;

  // reset images of the registers, split into their fields
  localparam logic [15:0] CfgRstWord = `TAC_CONFIG_RST;
  localparam logic [15:0] UpperRstWord = `TAC_UPPER_RST;
  localparam logic [15:0] LowerRstWord = `TAC_LOWER_RST;
  localparam tac_pkg::tac_cfg_t CfgRst = '{
    hyst: tac_pkg::tac_hyst_t'(CfgRstWord[`TAC_CFG_HYST_MSB:`TAC_CFG_HYST_LSB]),
    shutdown: CfgRstWord[`TAC_CFG_SHUTDOWN_BIT], critLock: CfgRstWord[`TAC_CFG_CRITLOCK_BIT],
    winLock: CfgRstWord[`TAC_CFG_WINLOCK_BIT], outEn: CfgRstWord[`TAC_CFG_OUTEN_BIT],
    critOnly: CfgRstWord[`TAC_CFG_CRITONLY_BIT], activeHigh: CfgRstWord[`TAC_CFG_POL_BIT],
    intMode: CfgRstWord[`TAC_CFG_MODE_BIT]};

  assign wd = regReq.wdata;
  assign cfgWr = regReq.wr && (regReq.addr == `TAC_OFS_CONFIG);
  assign upperWr = regReq.wr && (regReq.addr == `TAC_OFS_UPPER);
  assign lowerWr = regReq.wr && (regReq.addr == `TAC_OFS_LOWER);
  assign anyLock = cfg_r.winLock || cfg_r.critLock;

  // ----------------------------------------
  // configuration write
  // ----------------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    if (cfgWr) begin
      // lock state is judged before this write; locks land in it too
      if (!anyLock) begin
        cfg_nxt.intMode = wd[`TAC_CFG_MODE_BIT];
        cfg_nxt.activeHigh = wd[`TAC_CFG_POL_BIT];
        cfg_nxt.outEn = wd[`TAC_CFG_OUTEN_BIT];
        cfg_nxt.hyst = tac_pkg::tac_hyst_t'(wd[`TAC_CFG_HYST_MSB:`TAC_CFG_HYST_LSB]);
      end
      if (!cfg_r.winLock) begin
        cfg_nxt.critOnly = wd[`TAC_CFG_CRITONLY_BIT];
      end
      if (!wd[`TAC_CFG_SHUTDOWN_BIT] || !anyLock) begin
        cfg_nxt.shutdown = wd[`TAC_CFG_SHUTDOWN_BIT];
      end
      cfg_nxt.winLock = cfg_r.winLock | wd[`TAC_CFG_WINLOCK_BIT];
      cfg_nxt.critLock = cfg_r.critLock | wd[`TAC_CFG_CRITLOCK_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CfgRst;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // clear acts only in latched mode and leaves no stored bit
  assign clearReq = cfgWr && wd[`TAC_CFG_CLEAR_BIT] && cfg_r.intMode;

  // ----------------------------------------
  // window limits
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      upperLimit_r <= UpperRstWord[`TAC_THR_MSB:`TAC_THR_LSB];
      lowerLimit_r <= LowerRstWord[`TAC_THR_MSB:`TAC_THR_LSB];
    end else if (!cfg_r.winLock) begin
      if (upperWr) begin
        upperLimit_r <= wd[`TAC_THR_MSB:`TAC_THR_LSB];
      end
      if (lowerWr) begin
        lowerLimit_r <= wd[`TAC_THR_MSB:`TAC_THR_LSB];
      end
    end
  end

  // the critical limit register lives outside; it may load only when unlocked
  assign critWrAllow = !cfg_r.critLock;
  assign monitorEn = !cfg_r.shutdown;

  // ----------------------------------------
  // trip flags
  // ----------------------------------------
  tac_hyst_cmp u_cmp (
    .tempSample(tempSample),
    .upperLimit(upperLimit_r),
    .lowerLimit(lowerLimit_r),
    .critLimit(critLimit),
    .hyst(cfg_r.hyst),
    .tripNow(trip_r),
    .tripNxt(tripNxt)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trip_r <= '0;
    end else if (tempValid && !cfg_r.shutdown) begin
      trip_r <= tripNxt;
    end
  end

  assign tripStatus = trip_r;
  assign winOut = trip_r.aboveWin || trip_r.belowWin;

  // ----------------------------------------
  // latched mode
  // ----------------------------------------
  // any entry into or exit from the window is a crossing
  assign crossing = winOut != winOutPrev_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      winOutPrev_r <= 1'b0;
    end else begin
      winOutPrev_r <= winOut;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intLatch_r <= 1'b0;
    end else if (crossing && cfg_r.intMode && !cfg_r.shutdown) begin
      intLatch_r <= 1'b1;
    end else if (clearReq || !cfg_r.intMode) begin
      intLatch_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // alert generation
  // ----------------------------------------
  always_comb begin
    if (cfg_r.critOnly) begin
      evtRaw = trip_r.aboveCrit;
    end else if (cfg_r.intMode) begin
      evtRaw = intLatch_r || trip_r.aboveCrit;
    end else begin
      evtRaw = winOut || trip_r.aboveCrit;
    end
  end

  // critical trip forces the alert regardless of any clear
  assign evtActive = evtRaw && cfg_r.outEn && !cfg_r.shutdown;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      alertOut_r <= 1'b0;
      alertOe_r <= 1'b0;
    end else begin
      alertOut_r <= evtActive ^ !cfg_r.activeHigh;
      alertOe_r <= cfg_r.outEn;
    end
  end

  assign alertOut = alertOut_r;
  assign alertOe = alertOe_r;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_r <= 16'h0000;
      rdValid_r <= 1'b0;
    end else begin
      rdValid_r <= regReq.rd;
      if (regReq.rd) begin
        rdData_r <= 16'h0000;
        unique case (regReq.addr)
          `TAC_OFS_CONFIG: begin
            rdData_r[`TAC_CFG_MODE_BIT] <= cfg_r.intMode;
            rdData_r[`TAC_CFG_POL_BIT] <= cfg_r.activeHigh;
            rdData_r[`TAC_CFG_CRITONLY_BIT] <= cfg_r.critOnly;
            rdData_r[`TAC_CFG_OUTEN_BIT] <= cfg_r.outEn;
            rdData_r[`TAC_CFG_STATUS_BIT] <= evtActive;
            rdData_r[`TAC_CFG_WINLOCK_BIT] <= cfg_r.winLock;
            rdData_r[`TAC_CFG_CRITLOCK_BIT] <= cfg_r.critLock;
            rdData_r[`TAC_CFG_SHUTDOWN_BIT] <= cfg_r.shutdown;
            rdData_r[`TAC_CFG_HYST_MSB:`TAC_CFG_HYST_LSB] <= cfg_r.hyst;
          end
          `TAC_OFS_UPPER: rdData_r[`TAC_THR_MSB:`TAC_THR_LSB] <= upperLimit_r;
          `TAC_OFS_LOWER: rdData_r[`TAC_THR_MSB:`TAC_THR_LSB] <= lowerLimit_r;
          default: rdData_r <= 16'h0000;
        endcase
      end
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_window_locked:
  assert property (@(posedge core_clk) disable iff (rst)
    (cfg_r.winLock && (upperWr || lowerWr)) |=>
      ($stable(upperLimit_r) && $stable(lowerLimit_r)))
    else $error("window limit changed while locked");

  a_locks_sticky:
  assert property (@(posedge core_clk) disable iff (rst)
    (cfg_r.critLock || cfg_r.winLock) |=>
      ((cfg_r.critLock || !$past(cfg_r.critLock)) && (cfg_r.winLock || !$past(cfg_r.winLock))))
    else $error("lock bit dropped without reset");

  a_lock_same_write:
  assert property (@(posedge core_clk) disable iff (rst)
    (cfgWr && !anyLock && wd[`TAC_CFG_WINLOCK_BIT]) |=>
      (cfg_r.winLock && cfg_r.outEn == $past(wd[`TAC_CFG_OUTEN_BIT])))
    else $error("lock and fields not taken in one write");

  a_fields_frozen:
  assert property (@(posedge core_clk) disable iff (rst)
    (cfgWr && anyLock) |=> ($stable(cfg_r.intMode) && $stable(cfg_r.activeHigh)
      && $stable(cfg_r.outEn) && $stable(cfg_r.hyst)))
    else $error("locked field changed");

  a_shutdown_quiet:
  assert property (@(posedge core_clk) disable iff (rst)
    cfg_r.shutdown |=> (alertOut_r == !$past(cfg_r.activeHigh)))
    else $error("alert active during shutdown");

  a_shutdown_set_refused:
  assert property (@(posedge core_clk) disable iff (rst)
    (cfgWr && anyLock && !cfg_r.shutdown) |=> !cfg_r.shutdown)
    else $error("shutdown set while locked");

  a_shutdown_clear_taken:
  assert property (@(posedge core_clk) disable iff (rst)
    (cfgWr && !wd[`TAC_CFG_SHUTDOWN_BIT]) |=> !cfg_r.shutdown)
    else $error("shutdown clear refused");

  a_disabled_idle:
  assert property (@(posedge core_clk) disable iff (rst)
    !cfg_r.outEn |=> !alertOe)
    else $error("alert pin driven while disabled");

  a_clear_reads_zero:
  assert property (@(posedge core_clk) disable iff (rst)
    (regReq.rd && regReq.addr == `TAC_OFS_CONFIG) |=> !rdData[`TAC_CFG_CLEAR_BIT])
    else $error("clear bit read back as one");

  a_crit_holds:
  assert property (@(posedge core_clk) disable iff (rst)
    (trip_r.aboveCrit && cfg_r.outEn && !cfg_r.shutdown) |-> evtActive)
    else $error("critical trip not signalled");

  a_comparator_follows:
  assert property (@(posedge core_clk) disable iff (rst)
    (!cfg_r.intMode && !cfg_r.critOnly && cfg_r.outEn && !cfg_r.shutdown)
      |-> (evtActive == (winOut || trip_r.aboveCrit)))
    else $error("comparator alert does not follow window");

  a_latch_holds:
  assert property (@(posedge core_clk) disable iff (rst)
    (intLatch_r && cfg_r.intMode && !clearReq) |=> intLatch_r)
    else $error("latched alert dropped without clear");

endmodule
`default_nettype wire

// *** tac_host_model.sv ***
// host-side register master for the serial engine request port
`timescale 1ns/1ps
`default_nettype none
module tac_host_model (
  // clock
  input wire logic core_clk,
  // register port
  output tac_pkg::tac_req_t regReq,
  input wire logic [15:0] rdData,
  input wire logic rdValid
);
  initial regReq = '0;
  // one write strobe; released data lines show the inverse
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == 8'h01) ? (d & 16'h07ff) : d;
    @(posedge core_clk);
    regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    regReq.wr <= 1'b0;
    regReq.wdata <= ~v;
  endtask
  // one read strobe, answer awaited a bounded number of cycles
  task automatic rd(input logic [7:0] a, output logic [15:0] q, output bit ok);
    ok = 1'b0;
    q = '0;
    @(posedge core_clk);
    regReq.rd <= 1'b1;
    regReq.addr <= a;
    @(posedge core_clk);
    regReq.rd <= 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      if (rdValid === 1'b1) begin
        ok = 1'b1;
        q = rdData;
      end else begin
        @(posedge core_clk);
      end
    end
  endtask
endmodule
`default_nettype wire

// *** tac_config_thresholds_bench.sv ***
// self-checking bench for the configuration and threshold bank
`timescale 1ns/1ps
`default_nettype none
module tac_config_thresholds_bench;
  tac_pkg::tac_req_t req;
  tac_pkg::tac_trip_t tripStatus, expTrip;
  logic [15:0] rdData;
  logic [11:0] tempSample;
  logic [10:0] critLimit;
  logic core_clk, rst, tempValid, rdValid, monitorEn, critWrAllow, alertOut, alertOe;
  logic intMode, aHi, critOnly, outEn, sd;
  logic [1:0] h;
  logic [31:0] rnd;
  int miscompares, cmpCount;
  int hv[4];
  int cs[9];
  int up = 320;
  int lo = 128;
  int cr = 400;

  tac_host_model host (.core_clk(core_clk), .regReq(req), .rdData(rdData),
    .rdValid(rdValid));
  tac_config_thresholds dut (.core_clk(core_clk), .rst(rst), .regReq(req),
    .rdData(rdData), .rdValid(rdValid), .tempSample(tempSample), .tempValid(tempValid),
    .critLimit(critLimit), .monitorEn(monitorEn), .critWrAllow(critWrAllow),
    .tripStatus(tripStatus), .alertOut(alertOut), .alertOe(alertOe));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // expectation helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // flags in 0.125 degC units, m is the hysteresis margin
  function automatic tac_pkg::tac_trip_t nxtTrip(input tac_pkg::tac_trip_t p,
    input int t, input int m);
    nxtTrip = p;
    if (t > up) nxtTrip.aboveWin = 1'b1;
    else if (t <= up - m) nxtTrip.aboveWin = 1'b0;
    if (t >= lo) nxtTrip.belowWin = 1'b0;
    else if (t <= lo - m) nxtTrip.belowWin = 1'b1;
    if (t >= cr) nxtTrip.aboveCrit = 1'b1;
    else if (t < cr - m) nxtTrip.aboveCrit = 1'b0;
  endfunction
  // comparator-mode pin level
  function automatic logic expAlert();
    logic a;
    a = (critOnly ? expTrip.aboveCrit : |expTrip) & outEn & ~sd;
    return aHi ? a : ~a;
  endfunction

  // ----------------------------------------
  // compare, access and stimulus tasks
  // ----------------------------------------
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    cmpCount++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkBit(input logic got, input logic exp);
    chkWord({15'h0, got}, {15'h0, exp});
  endtask
  task automatic completeRun();
    $display("compares=%0d mismatches=%0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
    logic [15:0] q;
    bit ok;
    host.rd(a, q, ok);
    if (!ok) begin
      miscompares++;
      completeRun();
    end
    chkWord(q & m, e);
  endtask
  task automatic cfg(input logic [15:0] w);
    host.wr(8'h01, w);
    {h, sd} = {w[10:9], w[8]};
    {outEn, critOnly, aHi, intMode} = w[3:0];
    @(posedge core_clk);
    #1;
    chkBit(alertOe, outEn);
  endtask
  task automatic clr();
    host.wr(8'h01, 16'h002b);
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic sample(input int t);
    @(posedge core_clk);
    tempSample <= t[11:0];
    tempValid <= 1'b1;
    @(posedge core_clk);
    tempValid <= 1'b0;
    // the latched alert lags the flags by one more cycle
    repeat (2) @(posedge core_clk);
    #1;
    if (!sd) expTrip = nxtTrip(expTrip, t, hv[h]);
    chkWord(16'(tripStatus), 16'(expTrip));
    if (!intMode) chkBit(alertOut, expAlert());
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    tempSample = '0;
    tempValid = 1'b0;
    critLimit = 11'd200;
    expTrip = '0;
    {intMode, aHi, critOnly, outEn, sd, h} = '0;
    hv = '{0, 12, 24, 48};
    rnd = 32'h28483b2b;
    miscompares = 0;
    cmpCount = 0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(8'h01, 16'h0000, 16'hffff);
    rdChk(8'h07, 16'h0000, 16'hffff);
    chkBit(monitorEn & critWrAllow & ~alertOe, 1'b1);
    host.wr(8'h02, 16'hffff);
    rdChk(8'h02, 16'h1ffc, 16'hffff);
    host.wr(8'h03, 16'hffff);
    rdChk(8'h03, 16'h1ffc, 16'hffff);
    host.wr(8'h02, 16'h0280);
    host.wr(8'h03, 16'h0100);
    rdChk(8'h03, 16'h0100, 16'hffff);
    $display("reset and format test done");
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      cfg({5'h0, k[1:0], 6'h01, 1'b0, rnd[0], 1'b0});
      cs = '{up, up + 1, up - hv[k], lo, lo - 1, lo - hv[k], cr, cr - 1, cr - hv[k]};
      for (int i = 0; i < 40; i++) begin
        rnd = lfsr(rnd);
        sample(i < 9 ? cs[i] : int'(rnd[8:0]) - 40);
        if (i % 8 == 7) begin
          rdChk(8'h01, {5'h0, h, 4'h0, expAlert() ^ ~aHi, 2'b10, aHi, 1'b0}, 16'hffff);
          chkBit(alertOut, expAlert());
        end
      end
    end
    $display("random window test done");
    cfg(16'h000e);
    sample(up + 8);
    sample(cr);
    cfg(16'h0108);
    chkBit(monitorEn, 1'b0);
    sample(lo - 80);
    cfg(16'h0008);
    sample(200);
    $display("critical-only and shutdown test done");
    cfg(16'h000b);
    sample(up + 8);
    chkBit(alertOut, 1'b1);
    sample(200);
    chkBit(alertOut, 1'b1);
    clr();
    chkBit(alertOut, 1'b0);
    rdChk(8'h01, 16'h000b, 16'hffef);
    sample(cr + 8);
    clr();
    chkBit(alertOut, 1'b1);
    sample(cr - 8);
    chkBit(alertOut, 1'b0);
    $display("latched mode test done");
    cfg(16'h0148);
    chkBit(monitorEn, 1'b0);
    host.wr(8'h01, 16'h0048);
    rdChk(8'h01, 16'h0048, 16'hffef);
    chkBit(monitorEn, 1'b1);
    host.wr(8'h01, 16'h07cf);
    rdChk(8'h01, 16'h00c8, 16'hffef);
    chkBit(critWrAllow, 1'b0);
    host.wr(8'h02, 16'h0100);
    rdChk(8'h02, 16'h0280, 16'hffff);
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdChk(8'h01, 16'h0000, 16'hffff);
    chkBit(critWrAllow, 1'b1);
    $display("lock test done");
    completeRun();
  end
endmodule
`default_nettype wire
